/* bench/ocs_top_asserts.sv */
// Port-level checks for the oscillator control and status block
`timescale 1ns/1ns
module ocs_top_asserts
	import ocs_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic [1:0]        oscillator_config_word,
	input wire logic              fail_safe_monitor_fail,
	input wire logic              remap_write_req,
	input wire logic              remap_write_grant,
	input wire logic [SRC_W-1:0]  requested_source_sel,
	input wire logic              switch_freeze,
	input wire logic              pin_remap_write_guard,
	input wire logic              clock_fail_flag
);
	logic [7:0] aw_q;

	// Keep the write address, the response comes after the address is gone
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			aw_q <= 8'h00;
		else if (s_axi_awvalid && s_axi_awready)
			aw_q <= s_axi_awaddr;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Bus timing and responses
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write response late");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_cfg_err;
		$rose(s_axi_bvalid) && aw_q == OFS_CONFIG |-> s_axi_bresp == RESP_SLVERR;
	endproperty
	a_cfg_err: assert property (p_cfg_err) else $error("config write not refused");
	property p_rd_zero;
		s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[11] && !s_axi_rdata[4];
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("unused bits read nonzero");

	// Pin remap guard decides every grant one cycle later
	property p_grant;
		remap_write_req |=> remap_write_grant == !$past(pin_remap_write_guard);
	endproperty
	a_grant: assert property (p_grant) else $error("remap grant wrong");
	property p_grant_idle;
		!remap_write_req |=> !remap_write_grant;
	endproperty
	a_grant_idle: assert property (p_grant_idle) else $error("grant without request");

	// Freeze only in the monitor-off switching mode, and it holds the request
	property p_freeze_mode;
		(oscillator_config_word != MODE_SWITCH_NO_MONITOR) [*5] |-> !switch_freeze;
	endproperty
	a_freeze_mode: assert property (p_freeze_mode) else $error("freeze outside mode");
	property p_freeze_hold;
		$past(switch_freeze) |-> $stable(requested_source_sel);
	endproperty
	a_freeze_hold: assert property (p_freeze_hold) else $error("source changed while frozen");

	// Sticky clock failure flag, cleared only by a bus write
	property p_fail_set;
		fail_safe_monitor_fail [*5] |-> clock_fail_flag;
	endproperty
	a_fail_set: assert property (p_fail_set) else $error("fail flag not set");
	property p_fail_clear;
		$fell(clock_fail_flag) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_fail_clear: assert property (p_fail_clear) else $error("fail flag dropped alone");

	c_reject: cover property (remap_write_req && pin_remap_write_guard);
	c_fail: cover property ($fell(clock_fail_flag));
	c_freeze: cover property ($rose(switch_freeze));
endmodule : ocs_top_asserts

/* bench/test_ocs_top.sv */
// Self-checking bench for the oscillator control and status block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_ocs_top
	import ocs_pkg::*;
;
	logic        clk = 1'h0, rst_n = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, oscillator_config_word = 2'h0;
	logic [2:0]  active_source_sel = 3'h0, requested_source_sel;
	logic        pll_enabled = 1'h0, pll_in_lock = 1'h0, pll_timer_done = 1'h0;
	logic        fail_safe_monitor_fail = 1'h0, remap_write_req = 1'h0, remap_write_grant;
	logic        switch_freeze, pin_remap_write_guard, clock_fail_flag, irq;
	int          err_count = 0, n_compared = 0;
	// Rows: active code, requested code, expected readback
	logic [21:0] rows [8] = '{22'h387000, 22'h316100, 22'h2A5200, 22'h234300,
		22'h1C3400, 22'h152500, 22'h0E1600, 22'h070700};
	// Rows: enable, lock, timer, expected lock bit
	logic [3:0]  lock_rows [4] = '{4'h8, 4'hD, 4'hB, 4'h6};

	ocs_top u_ocs_top (.*);

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	task automatic conclude(input bit t);
		if (t)
			err_count++;
		$display("Compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
				break;
		end
		if (n == 40)
			conclude(1'h1);
		`CHK("bresp", er, s_axi_bresp)
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
				break;
		end
		if (n == 40)
			conclude(1'h1);
		`CHK("rdata", ed, s_axi_rdata)
		`CHK("rresp", er, s_axi_rresp)
	endtask : axi_rd

	// One-cycle remap attempt; the grant stands in the following cycle
	task automatic remap(input logic g);
		remap_write_req <= 1'h1;
		@(posedge clk);
		remap_write_req <= 1'h0;
		@(posedge clk);
		`CHK("grant", g, remap_write_grant)
	endtask : remap

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		axi_rd(OFS_CTRL, 32'h0, RESP_OKAY);
		axi_rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		axi_rd(8'h10, 32'h0, RESP_SLVERR);
		axi_wr(OFS_CONFIG, 32'h7, RESP_SLVERR);
		// Every source code; read-only and unused bits are written as ones
		foreach (rows[i])
		begin
			active_source_sel <= rows[i][21:19];
			axi_wr(OFS_CTRL, 32'hF83F | {rows[i][18:16], 8'h00}, RESP_OKAY);
			repeat (6) @(posedge clk);
			axi_rd(OFS_CTRL, {16'h0, rows[i][15:0]}, RESP_OKAY);
			`CHK("req", rows[i][18:16], requested_source_sel)
		end
		// Refused remap write, masked then unmasked interrupt
		axi_wr(OFS_CTRL, 32'h40, RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK("guard", 1'h1, pin_remap_write_guard)
		remap(1'h0);
		axi_rd(OFS_IRQ_STATUS, 32'h8, RESP_OKAY);
		`CHK("irq", 1'h0, irq)
		axi_wr(OFS_IRQ_MASK, 32'h8, RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK("irq", 1'h1, irq)
		axi_wr(OFS_IRQ_STATUS, 32'h8, RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK("irq", 1'h0, irq)
		axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
		remap(1'h1);
		// Freeze holds the request only in the monitor-off mode
		oscillator_config_word <= MODE_SWITCH_NO_MONITOR;
		repeat (6) @(posedge clk);
		axi_wr(OFS_CTRL, 32'h280, RESP_OKAY);
		axi_wr(OFS_CTRL, 32'h580, RESP_OKAY);
		axi_rd(OFS_CTRL, 32'h280, RESP_OKAY);
		axi_rd(OFS_CONFIG, 32'h5, RESP_OKAY);
		`CHK("freeze", 1'h1, switch_freeze)
		oscillator_config_word <= 2'h0;
		repeat (6) @(posedge clk);
		`CHK("freeze", 1'h0, switch_freeze)
		axi_wr(OFS_CTRL, 32'h580, RESP_OKAY);
		axi_rd(OFS_CTRL, 32'h580, RESP_OKAY);
		// PLL lock bit for four of the eight input combinations
		foreach (lock_rows[i])
		begin
			{pll_enabled, pll_in_lock, pll_timer_done} <= lock_rows[i][3:1];
			repeat (6) @(posedge clk);
			axi_rd(OFS_CTRL, 32'h580 | {lock_rows[i][0], 5'h0}, RESP_OKAY);
		end
		axi_rd(OFS_IRQ_STATUS, 32'h6, RESP_OKAY);
		axi_wr(OFS_IRQ_STATUS, 32'h6, RESP_OKAY);
		// Clock failure stays set after the monitor lets go
		fail_safe_monitor_fail <= 1'h1;
		repeat (6) @(posedge clk);
		fail_safe_monitor_fail <= 1'h0;
		repeat (6) @(posedge clk);
		`CHK("fail", 1'h1, clock_fail_flag)
		axi_wr(OFS_CTRL, 32'h588, RESP_OKAY);
		axi_rd(OFS_CTRL, 32'h588, RESP_OKAY);
		axi_rd(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
		axi_wr(OFS_CTRL, 32'h580, RESP_OKAY);
		axi_rd(OFS_CTRL, 32'h580, RESP_OKAY);
		// Second reset in mid-run
		rst_n <= 1'h0;
		repeat (3) @(posedge clk);
		`CHK("outs", 7'h0, {requested_source_sel, switch_freeze, pin_remap_write_guard, clock_fail_flag, irq})
		rst_n <= 1'h1;
		@(posedge clk);
		axi_rd(OFS_CTRL, 32'h0, RESP_OKAY);
		conclude(1'h0);
	end

	// Guard against a hang outside the bounded waits
	initial
	begin
		repeat (20000) @(posedge clk);
		conclude(1'h1);
	end
endmodule : test_ocs_top

bind ocs_top ocs_top_asserts u_ocs_top_asserts (.*);

/* hdl/ocs_axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ns
module ocs_axil_slave
	import ocs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	ocs_reg_if.bus_side            regs
);
	logic              aw_held, next_aw_held;
	logic              w_held, next_w_held;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [DATA_W-1:0] w_data, next_w_data;
	logic [3:0]        w_strb, next_w_strb;
	logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]        next_bresp, next_rresp;
	logic [DATA_W-1:0] next_rdata;

	// Address and data are caught in either order; the write fires once both are held
	always_comb
	begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		regs.wr_en = 1'b0;
		regs.wr_addr = {aw_addr[ADDR_W-1:2], 2'b00};
		regs.wr_data = w_data;
		regs.wr_strb = w_strb;
		regs.rd_en = s_axi_arvalid && s_axi_arready;
		regs.rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (aw_held && w_held && !s_axi_bvalid)
		begin
			regs.wr_en = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = regs.wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (regs.rd_en)
		begin
			next_rvalid = 1'b1;
			next_rdata = regs.rd_data;
			next_rresp = regs.rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		// One write and one read in flight at a time keeps the slave to a single held address and data word
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_arready = !next_rvalid;
	end

	// Channel registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule : ocs_axil_slave

/* hdl/ocs_pkg.sv */
// Constants shared by the oscillator control and status block
package ocs_pkg;
	// Bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFS_CONFIG = 8'h0C;

	// Field positions of oscillator_control
	localparam int ACTIVE_SRC_LSB = 12;
	localparam int REQ_SRC_LSB = 8;
	localparam int FREEZE_BIT = 7;
	localparam int GUARD_BIT = 6;
	localparam int LOCK_BIT = 5;
	localparam int FAIL_BIT = 3;
	localparam int SRC_W = 3;

	// Interrupt status and mask layout
	localparam int IRQ_W = 4;
	localparam int IRQ_CLOCK_FAIL = 0;
	localparam int IRQ_LOCK_GAINED = 1;
	localparam int IRQ_LOCK_LOST = 2;
	localparam int IRQ_REMAP_REJECT = 3;

	// Oscillator source codes
	localparam logic [2:0] SRC_FAST_RC = 3'h0;
	localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRIMARY = 3'h2;
	localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
	localparam logic [2:0] SRC_SECONDARY_LF = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
	localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
	localparam logic [2:0] SRC_FAST_RC_DIVN = 3'h7;

	// Clock-switch mode of the configuration word that arms the freeze bit
	localparam logic [1:0] MODE_SWITCH_NO_MONITOR = 2'h1;

	// Reset values
	localparam logic [2:0] RST_REQ_SRC = 3'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ocs_pkg

/* hdl/ocs_reg_if.sv */
// Register access strobes between the bus slave and the register file
`timescale 1ns/1ns
interface ocs_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_err;
	logic        rd_en;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_err;

	modport bus_side (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_err, rd_data, rd_err);
	modport reg_side (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface : ocs_reg_if

/* hdl/ocs_top.sv */
// Oscillator control and status register block with AXI4-Lite access
//
// Overview of operation
// R01: Bits 14-12 report active source, read-only
// R02: Bits 10-8 hold software's requested source
// R03: Codes 000,101,110,111: fast RC variants, low-power RC
// R04: Codes 001,010,011,100: PLL, primary, secondary sources
// R05: Bit 7 freezes source only in mode 01
// R06: Bit 6 set rejects pin-remap register writes
// R07: Bit 5 shows PLL locked or timer done; the code shows this only while pll_enabled is set
// R08: Bit 3 sticky clock fail, software clears
// R09: Bits 4 and 11 read zero, ignore writes
// R10: Writes to status fields are ignored
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
module ocs_top
	import ocs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [SRC_W-1:0]  active_source_sel,
	input  wire logic [1:0]        oscillator_config_word,
	input  wire logic              pll_enabled,
	input  wire logic              pll_in_lock,
	input  wire logic              pll_timer_done,
	input  wire logic              fail_safe_monitor_fail,
	input  wire logic              remap_write_req,
	output logic                   remap_write_grant,
	output logic [SRC_W-1:0]       requested_source_sel,
	output logic                   switch_freeze,
	output logic                   pin_remap_write_guard,
	output logic                   clock_fail_flag,
	output logic                   irq
);
	ocs_reg_if regs ();

	// Bus slave; all AXI outputs leave from its flip-flops
	ocs_axil_slave u_slave (
		.clk           (clk),
		.rst_n         (rst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.regs          (regs.bus_side)
	);

	// Merge new data into old under a byte-lane strobe
	function automatic logic [DATA_W-1:0] lane_merge(
		input logic [DATA_W-1:0] old_val,
		input logic [DATA_W-1:0] new_val,
		input logic [3:0]        strb
	);
		logic [DATA_W-1:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = new_val[i*8 +: 8];
		return res;
	endfunction : lane_merge

	// Two-stage synchronisers for every pin that comes from another clock
	// A pin level held for less than one clock can be missed entirely
	localparam int SYNC_W = SRC_W + 2 + 4;
	logic [SYNC_W-1:0] sync_meta, next_sync_meta;
	logic [SYNC_W-1:0] sync_out, next_sync_out;

	always_comb
	begin
		next_sync_meta = {active_source_sel, oscillator_config_word, pll_enabled, pll_in_lock,
			pll_timer_done, fail_safe_monitor_fail};
		next_sync_out = sync_meta;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync_meta <= '0;
			sync_out <= '0;
		end
		else
		begin
			sync_meta <= next_sync_meta;
			sync_out <= next_sync_out;
		end
	end

	// Synchronised copies; only the second stage is read, never the first
	logic [SRC_W-1:0] src_s;
	logic [1:0]       mode_s;
	logic             pll_en_s, pll_lock_s, pll_timer_s, fail_s;

	assign {src_s, mode_s, pll_en_s, pll_lock_s, pll_timer_s, fail_s} = sync_out;

	// A multi-bit code may be caught mid-change, so it is taken only after two equal samples
	logic [SRC_W-1:0] src_prev, next_src_prev;
	logic [SRC_W-1:0] active_src, next_active_src;

	always_comb
	begin
		next_src_prev = src_s;
		next_active_src = active_src;
		if (src_s == src_prev)
			next_active_src = src_s; // R01 R10
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			src_prev <= SRC_FAST_RC;
			active_src <= SRC_FAST_RC;
		end
		else
		begin
			src_prev <= next_src_prev;
			active_src <= next_active_src;
		end
	end

	// PLL lock status and fail history for edge events
	logic lock_st, next_lock_st;
	logic fail_prev, next_fail_prev;

	// A disabled PLL reads as unlocked whatever its lock and timer inputs say
	always_comb
	begin
		next_lock_st = pll_en_s && (pll_lock_s || pll_timer_s); // R07
		next_fail_prev = fail_s;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lock_st <= 1'b0;
			fail_prev <= 1'b0;
		end
		else
		begin
			lock_st <= next_lock_st;
			fail_prev <= next_fail_prev;
		end
	end

	// Control register state
	logic [SRC_W-1:0] req_src, next_req_src;
	logic             freeze, next_freeze;
	logic             guard, next_guard;
	logic             cf, next_cf;
	logic             freeze_eff;
	logic             ctrl_wr;
	logic [15:0]      ctrl_new;
	logic [15:0]      ctrl_rd;
	logic [31:0]      ctrl_merged;

	// Freeze only bites in the switching-without-monitor mode
	assign freeze_eff = freeze && (mode_s == MODE_SWITCH_NO_MONITOR); // R05
	assign ctrl_wr = regs.wr_en && (regs.wr_addr == OFS_CTRL);
	// Merge against the live read image so lanes left out of the strobe keep their value
	assign ctrl_merged = lane_merge({16'h0000, ctrl_rd}, regs.wr_data, regs.wr_strb);
	assign ctrl_new = ctrl_merged[15:0];

	always_comb
	begin
		next_req_src = req_src;
		next_freeze = freeze;
		next_guard = guard;
		next_cf = cf;
		if (ctrl_wr)
		begin
			// A frozen source refuses a new request; the old one stays
			if (!freeze_eff)
				next_req_src = ctrl_new[REQ_SRC_LSB +: SRC_W]; // R02 R03 R04 R05
			next_freeze = ctrl_new[FREEZE_BIT];
			next_guard = ctrl_new[GUARD_BIT]; // R06
			if (!ctrl_new[FAIL_BIT])
				next_cf = 1'b0; // R08
		end
		// Monitor failure wins over a clear in the same cycle
		if (fail_s)
			next_cf = 1'b1; // R08
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			req_src <= RST_REQ_SRC;
			freeze <= 1'b0;
			guard <= 1'b0;
			cf <= 1'b0;
		end
		else
		begin
			req_src <= next_req_src;
			freeze <= next_freeze;
			guard <= next_guard;
			cf <= next_cf;
		end
	end

	// Read image; unimplemented bits are tied low and never stored
	always_comb
	begin
		ctrl_rd = 16'h0000; // R09
		ctrl_rd[ACTIVE_SRC_LSB +: SRC_W] = active_src; // R01
		ctrl_rd[REQ_SRC_LSB +: SRC_W] = req_src; // R02
		ctrl_rd[FREEZE_BIT] = freeze;
		ctrl_rd[GUARD_BIT] = guard;
		ctrl_rd[LOCK_BIT] = lock_st; // R07
		ctrl_rd[FAIL_BIT] = cf; // R08
	end

	// Pin-remap write gate; rejected attempts raise an event
	logic grant, next_grant;
	logic reject_evt;

	// The guard is used as stored, so a write that sets it blocks from the next cycle
	assign reject_evt = remap_write_req && guard; // R06

	always_comb
	begin
		next_grant = remap_write_req && !guard; // R06
	end

	// Interrupt status (write one to clear) and mask
	logic [IRQ_W-1:0] irq_status, next_irq_status;
	logic [IRQ_W-1:0] irq_mask, next_irq_mask;
	logic [IRQ_W-1:0] events;
	logic             next_irq;

	always_comb
	begin
		events = '0;
		events[IRQ_CLOCK_FAIL] = fail_s && !fail_prev;
		events[IRQ_LOCK_GAINED] = next_lock_st && !lock_st;
		events[IRQ_LOCK_LOST] = !next_lock_st && lock_st;
		events[IRQ_REMAP_REJECT] = reject_evt;
		next_irq_status = irq_status;
		next_irq_mask = irq_mask;
		if (regs.wr_en && regs.wr_addr == OFS_IRQ_STATUS && regs.wr_strb[0])
			next_irq_status = irq_status & ~regs.wr_data[IRQ_W-1:0];
		if (regs.wr_en && regs.wr_addr == OFS_IRQ_MASK && regs.wr_strb[0])
			next_irq_mask = regs.wr_data[IRQ_W-1:0];
		// A new event beats a clear in the same cycle
		next_irq_status = next_irq_status | events;
		next_irq = |(next_irq_status & next_irq_mask);
	end

	// Status, mask and interrupt line are registered so irq leaves a flip-flop
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			irq_status <= '0;
			irq_mask <= RST_IRQ_MASK;
			irq <= 1'b0;
			grant <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			irq <= next_irq;
			grant <= next_grant;
		end
	end

	// Read decode; config shows the synced mode and the live freeze
	always_comb
	begin
		regs.rd_data = '0;
		regs.rd_err = 1'b0;
		unique case (regs.rd_addr)
			OFS_CTRL:       regs.rd_data[15:0] = ctrl_rd;
			OFS_IRQ_STATUS: regs.rd_data[IRQ_W-1:0] = irq_status;
			OFS_IRQ_MASK:   regs.rd_data[IRQ_W-1:0] = irq_mask;
			OFS_CONFIG:     regs.rd_data[2:0] = {freeze_eff, mode_s};
			default:        regs.rd_err = 1'b1;
		endcase
	end

	// Config is read-only; writes there or to holes answer with an error
	always_comb
	begin
		regs.wr_err = !(regs.wr_addr == OFS_CTRL || regs.wr_addr == OFS_IRQ_STATUS
			|| regs.wr_addr == OFS_IRQ_MASK);
	end

	// Outputs straight from flip-flops
	assign requested_source_sel = req_src;
	assign pin_remap_write_guard = guard;
	assign clock_fail_flag = cf;
	assign remap_write_grant = grant;

	// Freeze output is registered from the next freeze value, so it changes on the same edge as the stored bit
	logic next_freeze_out;

	always_comb
	begin
		next_freeze_out = next_freeze && (mode_s == MODE_SWITCH_NO_MONITOR); // R05
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			switch_freeze <= 1'b0;
		else
			switch_freeze <= next_freeze_out;
	end
endmodule : ocs_top
